// *** ecgf_defines.svh ***
// Constants for the ECG sample FIFO with tagging
//
// Notes on behaviour
// - Word bits 23:6 hold the 18-bit two's complement sample, left justified.
// - Bits 5:3 of every word hold the three-bit sample status tag.
// - Tag 000: valid voltage and time step, more samples remain.
// - Tag 001: fast recovery sample, voltage invalid, time step valid.
// - Tag 010: valid sample that is the last one held.
// - Tag 011: fast recovery sample that is the last one held.
// - Reading an empty FIFO returns a word tagged 110.
// - After overflow words are tagged 111 and the overflow flag is set.
// - FIFO reset command clears contents and the overflow state.
// - Resync command restarts channel timing and clears the sample FIFO.
// - Bits 2:0 of every word hold the three-bit pace group pointer.
// - Pace pointer 000 to 101 names the pace group of that sample.
// - Pace pointer 111 means no pace event for the sample.
// - FIFO is a 32 by 22-bit circular buffer with internal pointers.
// - Read pointer moves at serial edge 32, then every 24 in burst.
// - Interrupt flag rises when unread count reaches threshold 1 to 32.
`ifndef ECGF_DEFINES_SVH
`define ECGF_DEFINES_SVH
`define ECGF_DEPTH 6'h20
`define ECGF_FIRST_EDGE 6'h20
`define ECGF_BURST_EDGES 6'h18
`define ECGF_VOLT_LSB 6
`define ECGF_TAG_LSB 3
`define ECGF_PACE_LSB 0
`define ECGF_TAG_EMPTY 3'h6
`define ECGF_TAG_OVF 3'h7
`define ECGF_PACE_MAX 3'h5
`define ECGF_PACE_NONE 3'h7
`define ECGF_SYNC_RST 3'h0
`define ECGF_CSB_RST 3'h7
`endif

// *** ecgf_pkg.sv ***
// Types shared by the ECG sample FIFO files
package ecgf_pkg;
    typedef logic [23:0] ecgf_word_type;
    typedef logic [21:0] ecgf_entry_type;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_FIRST = 4'h2,
        ST_BURST = 4'h4,
        ST_HOLD = 4'h8
    } ecgf_state_type;
endpackage

// *** ecgf_skid.sv ***
// Two-entry word buffer between the FIFO read side and the host word port
`timescale 1ns/1ns
`default_nettype none
module ecgf_skid
(
    input wire logic clk,
    input wire logic rst_n,
    input wire ecgf_pkg::ecgf_word_type in_data,
    input wire logic in_valid,
    output logic in_ready,
    output ecgf_pkg::ecgf_word_type out_data,
    output logic out_valid,
    input wire logic out_ready
);
    import ecgf_pkg::*;

    ecgf_word_type d0_q, d1_q, d0_d, d1_d;
    logic [1:0] cnt_q, cnt_d;
    logic push, pop;

    assign in_ready = (cnt_q != 2'h2);
    assign out_valid = (cnt_q != 2'h0);
    assign out_data = d0_q;
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always_comb
    begin
        d0_d = d0_q;
        d1_d = d1_q;
        cnt_d = cnt_q;
        if (pop)
        begin
            d0_d = d1_q;
        end
        if (push)
        begin
            if (cnt_q == 2'h0 || (cnt_q == 2'h1 && pop))
            begin
                d0_d = in_data;
            end
            else
            begin
                d1_d = in_data;
            end
        end
        cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            d0_q <= 24'h000000;
            d1_q <= 24'h000000;
            cnt_q <= 2'h0;
        end
        else
        begin
            d0_q <= d0_d;
            d1_q <= d1_d;
            cnt_q <= cnt_d;
        end
    end
endmodule // ecgf_skid
`default_nettype wire

// *** ecgf_top.sv ***
// ECG sample FIFO with status and pace tagging, read by serial clock edges
`timescale 1ns/1ns
`default_nettype none
`include "ecgf_defines.svh"
module ecgf_top
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic sample_strobe,
    input wire logic [17:0] sample_voltage,
    input wire logic sample_fast,
    input wire logic pace_hit,
    input wire logic [2:0] pace_group_pointer,
    input wire logic fifo_reset_cmd,
    input wire logic channel_resync_cmd,
    input wire logic [4:0] ecg_irq_threshold,
    input wire logic burst_mode,
    input wire logic sclk_pin,
    input wire logic csb_n_pin,
    output ecgf_pkg::ecgf_word_type word_data,
    output logic word_valid,
    input wire logic word_ready,
    output logic ecg_overflow_flag,
    output logic ecg_irq_flag,
    output logic [5:0] unread_count,
    output logic timing_restart
);
    import ecgf_pkg::*;

    // Builds the host word from the head entry and the FIFO state
    function automatic ecgf_word_type make_word(input ecgf_entry_type e,
        input logic [5:0] cnt, input logic ovf);
        ecgf_word_type w;
        w = 24'h000000;
        if (ovf)
        begin
            w[`ECGF_TAG_LSB +: 3] = `ECGF_TAG_OVF;
            w[`ECGF_PACE_LSB +: 3] = `ECGF_PACE_NONE;
        end
        else if (cnt == 6'h00)
        begin
            w[`ECGF_TAG_LSB +: 3] = `ECGF_TAG_EMPTY;
            w[`ECGF_PACE_LSB +: 3] = `ECGF_PACE_NONE;
        end
        else
        begin
            w[`ECGF_VOLT_LSB +: 18] = e[17:0];
            // Bit 2 stays zero, so 100 and 101 cannot appear
            w[`ECGF_TAG_LSB +: 3] = {1'b0, cnt == 6'h01, e[21]};
            w[`ECGF_PACE_LSB +: 3] = e[20:18];
        end
        return w;
    endfunction

    // Reset release through two flops
    logic [1:0] rst_q;
    logic rst_n;
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rst_q <= 2'h0;
        end
        else
        begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_n = rst_q[1];

    // Pin synchronisers; stage 0 feeds only stage 1
    logic [2:0] sclk_s_q, csb_s_q;
    logic sclk_lvl_q, sclk_lvl_d, csb_lvl_q, csb_lvl_d;
    logic sclk_rise, cs_act;

    always_comb
    begin
        sclk_lvl_d = (sclk_s_q[1] == sclk_s_q[2]) ? sclk_s_q[2] : sclk_lvl_q;
        csb_lvl_d = (csb_s_q[1] == csb_s_q[2]) ? csb_s_q[2] : csb_lvl_q;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sclk_s_q <= `ECGF_SYNC_RST;
            csb_s_q <= `ECGF_CSB_RST;
            sclk_lvl_q <= 1'b0;
            csb_lvl_q <= 1'b1;
        end
        else
        begin
            sclk_s_q <= {sclk_s_q[1:0], sclk_pin};
            csb_s_q <= {csb_s_q[1:0], csb_n_pin};
            sclk_lvl_q <= sclk_lvl_d;
            csb_lvl_q <= csb_lvl_d;
        end
    end
    assign sclk_rise = sclk_lvl_d & ~sclk_lvl_q;
    assign cs_act = ~csb_lvl_q;

    // Sample memory and pointers
    ecgf_entry_type mem [0:31];
    logic [4:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
    logic [5:0] count_q, count_d;
    logic ovf_q, ovf_d, irq_q, irq_d, restart_q;
    logic flush, full, do_wr, do_rd, pop_go;
    logic [2:0] pace_in;
    logic [5:0] thr;

    assign flush = fifo_reset_cmd | channel_resync_cmd;
    assign full = (count_q == `ECGF_DEPTH);
    assign thr = {1'b0, ecg_irq_threshold} + 6'h01;
    // Out-of-range groups fold to no pace, so 110 is never stored
    assign pace_in = (pace_hit && pace_group_pointer <= `ECGF_PACE_MAX) ?
        pace_group_pointer : `ECGF_PACE_NONE;
    // A sample arriving with a flush is dropped with the old contents
    assign do_wr = sample_strobe & ~full & ~flush;
    // Overflowed FIFO holds still until cleared
    assign do_rd = pop_go & (count_q != 6'h00) & ~ovf_q & ~flush;

    always_comb
    begin
        wr_ptr_d = wr_ptr_q;
        rd_ptr_d = rd_ptr_q;
        count_d = count_q;
        ovf_d = ovf_q;
        if (flush)
        begin
            wr_ptr_d = 5'h00;
            rd_ptr_d = 5'h00;
            count_d = 6'h00;
            ovf_d = 1'b0;
        end
        else
        begin
            if (sample_strobe && full)
            begin
                ovf_d = 1'b1;
            end
            wr_ptr_d = wr_ptr_q + {4'h0, do_wr};
            rd_ptr_d = rd_ptr_q + {4'h0, do_rd};
            count_d = count_q + {5'h00, do_wr} - {5'h00, do_rd};
        end
        irq_d = (count_d >= thr);
    end

    always_ff @(posedge clk)
    begin
        if (do_wr)
        begin
            mem[wr_ptr_q] <= {sample_fast, pace_in, sample_voltage};
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ptr_q <= 5'h00;
            rd_ptr_q <= 5'h00;
            count_q <= 6'h00;
            ovf_q <= 1'b0;
            irq_q <= 1'b0;
            restart_q <= 1'b0;
        end
        else
        begin
            wr_ptr_q <= wr_ptr_d;
            rd_ptr_q <= rd_ptr_d;
            count_q <= count_d;
            ovf_q <= ovf_d;
            irq_q <= irq_d;
            restart_q <= channel_resync_cmd;
        end
    end

    assign ecg_overflow_flag = ovf_q;
    assign ecg_irq_flag = irq_q;
    assign unread_count = count_q;
    assign timing_restart = restart_q;

    // Serial edge counting; a pop waits while the buffer is full
    ecgf_state_type st_q, st_d;
    logic [5:0] edge_q, edge_d, edge_inc;
    logic pend_q, pend_d, buf_ready;
    ecgf_word_type head_word;

    assign edge_inc = edge_q + 6'h01;
    assign pop_go = pend_q & buf_ready;
    assign head_word = make_word(mem[rd_ptr_q], count_q, ovf_q);

    always_comb
    begin
        st_d = st_q;
        edge_d = edge_q;
        pend_d = pend_q & ~buf_ready;
        case (st_q)
            ST_IDLE:
            begin
                edge_d = 6'h00;
                if (cs_act)
                begin
                    st_d = ST_FIRST;
                end
            end
            ST_FIRST:
            begin
                if (!cs_act)
                begin
                    st_d = ST_IDLE;
                end
                else if (sclk_rise)
                begin
                    edge_d = edge_inc;
                    if (edge_inc == `ECGF_FIRST_EDGE)
                    begin
                        pend_d = 1'b1;
                        edge_d = 6'h00;
                        st_d = burst_mode ? ST_BURST : ST_HOLD;
                    end
                end
            end
            ST_BURST:
            begin
                if (!cs_act)
                begin
                    st_d = ST_IDLE;
                end
                else if (sclk_rise)
                begin
                    edge_d = edge_inc;
                    if (edge_inc == `ECGF_BURST_EDGES)
                    begin
                        pend_d = 1'b1;
                        edge_d = 6'h00;
                    end
                end
            end
            ST_HOLD:
            begin
                if (!cs_act)
                begin
                    st_d = ST_IDLE;
                end
            end
            default:
            begin
                st_d = ST_IDLE;
                edge_d = 6'h00;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q <= ST_IDLE;
            edge_q <= 6'h00;
            pend_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            edge_q <= edge_d;
            pend_q <= pend_d;
        end
    end

    ecgf_skid u_skid
    (
        .clk(clk),
        .rst_n(rst_n),
        .in_data(head_word),
        .in_valid(pend_q),
        .in_ready(buf_ready),
        .out_data(word_data),
        .out_valid(word_valid),
        .out_ready(word_ready)
    );

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    property p_volt;
        do_wr |=> mem[$past(wr_ptr_q)] ==
            {$past(sample_fast), $past(pace_in), $past(sample_voltage)};
    endproperty
    a_volt: assert property (p_volt) else $error("sample not stored whole");

    property p_valid_more;
        pop_go && count_q > 6'h01 && !ovf_q |-> head_word[5:4] == 2'h0;
    endproperty
    a_valid_more: assert property (p_valid_more) else $error("tag not plain");

    property p_last;
        pop_go && count_q == 6'h01 && !ovf_q |-> head_word[5:4] == 2'h1;
    endproperty
    a_last: assert property (p_last) else $error("end tag missing");

    property p_empty;
        pop_go && count_q == 6'h00 && !ovf_q |-> head_word[5:3] == `ECGF_TAG_EMPTY;
    endproperty
    a_empty: assert property (p_empty) else $error("empty tag missing");

    property p_ovf;
        sample_strobe && full && !flush |=> ovf_q ##0 (head_word[5:3] == `ECGF_TAG_OVF);
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow not flagged");

    property p_flush;
        flush |=> count_q == 6'h00 && !ecg_overflow_flag;
    endproperty
    a_flush: assert property (p_flush) else $error("flush did not clear");

    property p_resync;
        channel_resync_cmd |=> timing_restart && unread_count == 6'h00;
    endproperty
    a_resync: assert property (p_resync) else $error("resync incomplete");

    property p_codes;
        pend_q |-> head_word[5:4] != 2'h2 && head_word[2:0] != 3'h6;
    endproperty
    a_codes: assert property (p_codes) else $error("unused code emitted");

    property p_edge32;
        st_q == ST_FIRST && cs_act && sclk_rise && edge_q == 6'h1F |=> pend_q;
    endproperty
    a_edge32: assert property (p_edge32) else $error("no pop at edge 32");

    property p_depth;
        unread_count <= `ECGF_DEPTH;
    endproperty
    a_depth: assert property (p_depth) else $error("count past depth");

    property p_irq;
        $stable(ecg_irq_threshold) |-> ecg_irq_flag == (unread_count >= thr);
    endproperty
    a_irq: assert property (p_irq) else $error("irq flag wrong");

    c_read: cover property (do_rd && count_q > 6'h01);
    c_empty: cover property (pop_go && count_q == 6'h00);
    c_ovf: cover property (sample_strobe && full);
    c_stall: cover property (pend_q && !buf_ready);
endmodule // ecgf_top
`default_nettype wire

// *** ecgf_host_model.sv ***
// Host model: selects the part, clocks serial reads and takes words
`timescale 1ns/1ns
`default_nettype none
module ecgf_host_model
(
    input wire logic clk,
    input wire ecgf_pkg::ecgf_word_type word_data,
    input wire logic word_valid,
    input wire logic stall,
    output logic sclk_pin,
    output logic csb_n_pin,
    output logic word_ready
);
    import ecgf_pkg::*;
    ecgf_word_type got_q[$];
    initial
    begin
        sclk_pin = 1'b0;
        csb_n_pin = 1'b1;
    end
    // Slow host simply holds ready low
    assign word_ready = !stall;
    always @(posedge clk)
    begin
        if (word_valid && word_ready)
        begin
            got_q.push_back(word_data);
        end
    end
    // Serial clock stands still outside a select; 32 edges, then 24 per extra word
    task automatic read_frame(input int words);
        int edges;
        edges = 32 + 24 * (words - 1);
        csb_n_pin = 1'b0;
        #1000;
        repeat (edges)
        begin
            #200 sclk_pin = 1'b1;
            #200 sclk_pin = 1'b0;
        end
        #1000;
        csb_n_pin = 1'b1;
        #1000;
    endtask
endmodule // ecgf_host_model
`default_nettype wire

// *** ecg_fifo_sample_tagging_tb.sv ***
// Bench for the ECG sample FIFO: tags, pace pointers, stall, overflow, flush
`timescale 1ns/1ns
`default_nettype none
module ecg_fifo_sample_tagging_tb;
    import ecgf_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic sample_strobe = 1'b0;
    logic [17:0] sample_voltage = 18'h00000;
    logic sample_fast = 1'b0;
    logic pace_hit = 1'b0;
    logic [2:0] pace_group_pointer = 3'h0;
    logic fifo_reset_cmd = 1'b0;
    logic channel_resync_cmd = 1'b0;
    logic [4:0] ecg_irq_threshold = 5'h02;
    logic burst_mode = 1'b0;
    logic stall = 1'b0;
    logic sclk_pin;
    logic csb_n_pin;
    logic word_ready;
    ecgf_word_type word_data;
    logic word_valid;
    logic ecg_overflow_flag;
    logic ecg_irq_flag;
    logic [5:0] unread_count;
    logic timing_restart;
    int num_errors = 0;
    int checks = 0;
    always #25 clk = ~clk;
    ecgf_top DUT
    (
        .clk(clk),
        .nrst(nrst),
        .sample_strobe(sample_strobe),
        .sample_voltage(sample_voltage),
        .sample_fast(sample_fast),
        .pace_hit(pace_hit),
        .pace_group_pointer(pace_group_pointer),
        .fifo_reset_cmd(fifo_reset_cmd),
        .channel_resync_cmd(channel_resync_cmd),
        .ecg_irq_threshold(ecg_irq_threshold),
        .burst_mode(burst_mode),
        .sclk_pin(sclk_pin),
        .csb_n_pin(csb_n_pin),
        .word_data(word_data),
        .word_valid(word_valid),
        .word_ready(word_ready),
        .ecg_overflow_flag(ecg_overflow_flag),
        .ecg_irq_flag(ecg_irq_flag),
        .unread_count(unread_count),
        .timing_restart(timing_restart)
    );
    ecgf_host_model host
    (
        .clk(clk),
        .word_data(word_data),
        .word_valid(word_valid),
        .stall(stall),
        .sclk_pin(sclk_pin),
        .csb_n_pin(csb_n_pin),
        .word_ready(word_ready)
    );
    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Inputs change 2 ns after the edge, never on it
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task automatic put(input logic [17:0] v, input logic f, input logic h, input logic [2:0] g);
        sample_voltage = v;
        sample_fast = f;
        pace_hit = h;
        pace_group_pointer = g;
        sample_strobe = 1'b1;
        tick(1);
        sample_strobe = 1'b0;
        tick(1);
    endtask
    // Bounded wait for the host to hold a word
    task automatic get(input string what, input logic [23:0] exp);
        int n;
        n = 0;
        while (host.got_q.size() == 0 && n < 4000)
        begin
            tick(1);
            n++;
        end
        if (host.got_q.size() == 0)
        begin
            num_errors++;
            final_report();
        end
        else
        begin
            check(what, host.got_q.pop_front(), exp);
        end
    endtask
    initial
    begin
        tick(6);
        nrst = 1'b1;
        tick(3);
        check("count at reset", {18'h00000, unread_count}, 24'h000000);
        check("valid at reset", {23'h000000, word_valid}, 24'h000000);
        put(18'h2ABCD, 1'b0, 1'b1, 3'h2);
        put(18'h1F00F, 1'b1, 1'b0, 3'h4);
        check("irq below", {23'h000000, ecg_irq_flag}, 24'h000000);
        put(18'h3FFFF, 1'b0, 1'b1, 3'h5);
        check("irq at", {23'h000000, ecg_irq_flag}, 24'h000001);
        check("count", {18'h00000, unread_count}, 24'h000003);
        burst_mode = 1'b1;
        host.read_frame(4);
        get("w0", {18'h2ABCD, 3'h0, 3'h2});
        get("w1", {18'h1F00F, 3'h1, 3'h7});
        get("w2", {18'h3FFFF, 3'h2, 3'h5});
        get("empty", 24'h000037);
        burst_mode = 1'b0;
        put(18'h00001, 1'b1, 1'b1, 3'h6);
        // Next read only once a new sample is held
        host.read_frame(1);
        get("fast last", {18'h00001, 3'h3, 3'h7});
        check("drained", {18'h00000, unread_count}, 24'h000000);
        // Stalled host: two words park in the buffer, third pop waits
        stall = 1'b1;
        for (int i = 0; i < 3; i++)
            put({16'h4000, i[1:0]}, 1'b0, 1'b0, 3'h0);
        burst_mode = 1'b1;
        host.read_frame(3);
        check("none taken", 24'(host.got_q.size()), 24'h000000);
        check("held valid", {23'h000000, word_valid}, 24'h000001);
        stall = 1'b0;
        for (int i = 0; i < 3; i++)
            get("stalled", {16'h4000, i[1:0], (i == 2) ? 3'h2 : 3'h0, 3'h7});
        burst_mode = 1'b0;
        for (int i = 0; i < 33; i++)
            put({16'h0123, i[1:0]}, 1'b0, 1'b0, 3'h0);
        check("full count", {18'h00000, unread_count}, 24'h000020);
        check("overflow", {23'h000000, ecg_overflow_flag}, 24'h000001);
        host.read_frame(1);
        get("ovf word", 24'h00003F);
        check("ovf count", {18'h00000, unread_count}, 24'h000020);
        // Overflow answered by a flush
        fifo_reset_cmd = 1'b1;
        tick(1);
        fifo_reset_cmd = 1'b0;
        tick(1);
        check("flush count", {18'h00000, unread_count}, 24'h000000);
        check("flush ovf", {23'h000000, ecg_overflow_flag}, 24'h000000);
        put(18'h20000, 1'b0, 1'b0, 3'h7);
        host.read_frame(1);
        get("after flush", {18'h20000, 3'h2, 3'h7});
        put(18'h00005, 1'b0, 1'b0, 3'h0);
        put(18'h00006, 1'b0, 1'b0, 3'h0);
        channel_resync_cmd = 1'b1;
        tick(1);
        channel_resync_cmd = 1'b0;
        check("restart", {23'h000000, timing_restart}, 24'h000001);
        check("resync count", {18'h00000, unread_count}, 24'h000000);
        tick(1);
        check("restart once", {23'h000000, timing_restart}, 24'h000000);
        final_report();
    end
endmodule // ecg_fifo_sample_tagging_tb
`default_nettype wire
